// ---- hdl/dmamc_pkg.sv ----
// constants shared by the dma global control block and its buffer memory
// assumes a 32-bit register port with byte offsets on an 8-bit address
// Contract
// - done status is chain-or-transfer enabled completion
// - bits 17:14 show buffer valid count
// - bits 13:11 show next write location
// - bits 10:8 show next read location
// - halted transfers leave count and pointers intact
// - writing bit 7 zeroes pointers and count
// - buffer usable only by channels with mask
// - bit 2 selects little or big endian
// - rotating mode demotes last serviced channel
// - fixed mode ranks channel 0 highest
// - snoop and plain groups arbitrate separately
// - requests ignored while global enable clear
// - global enable clear holds logic reset
// - bits 31:28 error status enable and abnormal
package dmamc_pkg;
   localparam int NCH = 4;                         // channel count
   localparam int DATA_W = 32;                     // register and buffer word width
   localparam int ADDR_W = 8;                      // register address width
   localparam int BUF_DEPTH = 8;                   // buffer words
   localparam int PTR_W = 3;                       // buffer pointer width
   localparam int CNT_W = 4;                       // buffer count width
   localparam int IRQ_W = 8;                       // sticky event bits
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'ha4;        // global control and status
   localparam logic [7:0] OFF_IRQ_STAT = 8'ha8;    // sticky events, read clears
   localparam logic [7:0] OFF_IRQ_MASK = 8'hac;    // event mask
   // control word field positions
   localparam int ERR_LSB = 28;                    // error status per channel
   localparam int DONE_LSB = 24;                   // done status per channel
   localparam int CNT_LSB = 14;                    // valid count
   localparam int WP_LSB = 11;                     // write pointer
   localparam int RP_LSB = 8;                      // read pointer
   localparam int CLR_BIT = 7;                     // buffer clear, write one
   localparam int UMASK_LSB = 3;                   // buffer use mask
   localparam int LE_BIT = 2;                      // byte order select
   localparam int ROTATING_PRIORITY_SELECT_BIT = 1;                    // rotating priority select
   localparam int EN_BIT = 0;                      // global channel enable
   // sticky event layout
   localparam int IRQ_DONE_LSB = 0;                // done edges, channels 3..0
   localparam int IRQ_ERR_LSB = 4;                 // error edges, channels 3..0
   // reset values
   localparam logic [3:0] UMASK_RST = 4'h0;
   localparam logic LE_RST = 1'b0;
   localparam logic ROTATING_PRIORITY_SELECT_RST = 1'b0;
   localparam logic EN_RST = 1'b0;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [CNT_W-1:0] BUF_FULL = 4'h8;   // count when every word holds data
endpackage : dmamc_pkg

// ---- hdl/dmamc_mem_if.sv ----
// port bundle between the control block and its buffer memory
// assumes one clock; read data returns one cycle after the read strobe
`timescale 1ns/10ps
interface dmamc_mem_if #(parameter int WIDTH = 32, parameter int AW = 3);
   logic we;                // write strobe
   logic [AW-1:0] waddr;    // write location
   logic [WIDTH-1:0] wdata; // write word
   logic re;                // read strobe
   logic [AW-1:0] raddr;    // read location
   logic [WIDTH-1:0] rdata; // registered read word
   modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface : dmamc_mem_if

// ---- hdl/dmamc_mem.sv ----
// small word memory for the shared transfer buffer
// assumes the controller never reads and writes beyond its depth
`timescale 1ns/10ps
module dmamc_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   dmamc_mem_if.mem port
);
   logic [WIDTH-1:0] store [DEPTH];   // data words, no reset needed
   logic [WIDTH-1:0] rdata_reg;       // registered read word
   logic [WIDTH-1:0] rdata_next;

   // read word selection
   always_comb begin
      rdata_next = rdata_reg;
      if (port.re) begin
         rdata_next = store[port.raddr];
      end
   end

   // array write, kept free of reset so it maps onto plain storage
   always_ff @(posedge clk) begin
      if (port.we) begin
         store[port.waddr] <= port.wdata;
      end
   end

   // read register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign port.rdata = rdata_reg;
endmodule : dmamc_mem

// ---- hdl/dmamc_top.sv ----
// global control of a four-channel dma unit: status, shared buffer, arbiter
// assumes channel flags and buffer strobes come from logic on CLK;
// dma request pins are asynchronous and are synchronised here
`timescale 1ns/10ps
module dmamc_top (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [7:0] BUS_ADDR,
   input wire logic [31:0] BUS_WDATA,
   input wire logic BUS_WR,
   input wire logic BUS_RD,
   output logic [31:0] BUS_RDATA,
   input wire logic [3:0] CH_IRQ_CHAIN_EN,
   input wire logic [3:0] CH_IRQ_XFER_EN,
   input wire logic [3:0] CH_CHAIN_NORMAL,
   input wire logic [3:0] CH_XFER_NORMAL,
   input wire logic [3:0] CH_IRQ_ERR_EN,
   input wire logic [3:0] CH_CHAIN_ABNORMAL,
   input wire logic [3:0] CH_SNOOP,
   input wire logic [3:0] DMA_REQ,
   input wire logic [3:0] SVC_DONE,
   output logic [3:0] GRANT,
   output logic ENGINE_RESET_N,
   output logic BYTE_ORDER_LE,
   input wire logic FIFO_WR,
   input wire logic [1:0] FIFO_WR_CH,
   input wire logic [31:0] FIFO_WDATA,
   output logic FIFO_WR_READY,
   input wire logic FIFO_RD,
   input wire logic [1:0] FIFO_RD_CH,
   output logic FIFO_RD_READY,
   output logic [31:0] FIFO_RDATA,
   output logic IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);

   // pick one channel; rotating search starts just past the last serviced
   function automatic logic [3:0] dmamc_pick(input logic [3:0] req, input logic [1:0] last,
                                             input logic rot);
      logic [1:0] idx;
      logic [3:0] res;
      res = 4'h0;
      for (int k = 0; k < dmamc_pkg::NCH; k++) begin
         idx = rot ? last + 2'(k + 1) : 2'(k);
         if (res == 4'h0 && req[idx]) begin
            res[idx] = 1'b1;
         end
      end
      return res;
   endfunction : dmamc_pick

   // register strobes
   logic ctrl_wr;                 // write to the control word
   logic stat_rd;                 // read of sticky events, clears them
   logic mask_wr;                 // write to the event mask
   assign ctrl_wr = BUS_WR && (BUS_ADDR == dmamc_pkg::OFF_CTRL);
   assign stat_rd = BUS_RD && (BUS_ADDR == dmamc_pkg::OFF_IRQ_STAT);
   assign mask_wr = BUS_WR && (BUS_ADDR == dmamc_pkg::OFF_IRQ_MASK);

   // ---- control fields
   logic [3:0] umask_reg, umask_next;   // buffer use mask per channel
   logic le_reg, le_next;               // byte order select
   logic rotating_priority_select_reg, rotating_priority_select_next;           // rotating priority select
   logic en_reg, en_next;               // global channel enable
   logic buf_clear;                     // buffer pointers and count to zero

   // control field next values
   always_comb begin
      umask_next = umask_reg;
      le_next = le_reg;
      rotating_priority_select_next = rotating_priority_select_reg;
      en_next = en_reg;
      if (ctrl_wr) begin
         umask_next = BUS_WDATA[dmamc_pkg::UMASK_LSB +: dmamc_pkg::NCH];
         le_next = BUS_WDATA[dmamc_pkg::LE_BIT];
         rotating_priority_select_next = BUS_WDATA[dmamc_pkg::ROTATING_PRIORITY_SELECT_BIT];
         en_next = BUS_WDATA[dmamc_pkg::EN_BIT];
      end
   end

   // control field registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         umask_reg <= dmamc_pkg::UMASK_RST;
         le_reg <= dmamc_pkg::LE_RST;
         rotating_priority_select_reg <= dmamc_pkg::ROTATING_PRIORITY_SELECT_RST;
         en_reg <= dmamc_pkg::EN_RST;
      end else begin
         umask_reg <= umask_next;
         le_reg <= le_next;
         rotating_priority_select_reg <= rotating_priority_select_next;
         en_reg <= en_next;
      end
   end

   assign BYTE_ORDER_LE = le_reg;
   assign ENGINE_RESET_N = en_reg;   // engines held in reset while disabled

   AST_LE_SEL: assert property (ctrl_wr |=> BYTE_ORDER_LE == $past(BUS_WDATA[2]))
      else $error("byte order select did not follow write");

   // ---- live channel status
   logic [3:0] done_now;   // done condition per channel
   logic [3:0] err_now;    // error condition per channel
   assign done_now = (CH_IRQ_CHAIN_EN & CH_CHAIN_NORMAL) | (CH_IRQ_XFER_EN & CH_XFER_NORMAL);
   assign err_now = CH_IRQ_ERR_EN & CH_CHAIN_ABNORMAL;

   // ---- dma request synchroniser, three stages with agreement filter
   logic [3:0] req_s1_reg, req_s2_reg, req_s3_reg;   // synchroniser stages
   logic [3:0] req_flt_reg, req_flt_next;            // filtered request level

   // filtered level moves only when stages two and three agree
   always_comb begin
      req_flt_next = (req_s2_reg & req_s3_reg) | (req_flt_reg & (req_s2_reg | req_s3_reg));
   end

   // synchroniser registers; the enable masks the filtered level further on
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         req_s1_reg <= 4'h0;
         req_s2_reg <= 4'h0;
         req_s3_reg <= 4'h0;
         req_flt_reg <= 4'h0;
      end else begin
         req_s1_reg <= DMA_REQ;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
         req_flt_reg <= req_flt_next;
      end
   end

   // ---- arbiter, one search per snoop group
   logic [3:0] req;                          // requests that may be served
   logic [3:0] grant_reg, grant_next;        // one-hot per group
   logic [1:0] last_s_reg, last_s_next;      // last serviced, snoop group
   logic [1:0] last_p_reg, last_p_next;      // last serviced, plain group
   assign req = req_flt_reg & {4{en_reg}};

   // grant held until the engine reports service done or the global enable clears
   always_comb begin
      grant_next = grant_reg;
      last_s_next = last_s_reg;
      last_p_next = last_p_reg;
      if (!en_reg) begin
         grant_next = 4'h0;
         last_s_next = 2'h0;
         last_p_next = 2'h0;
      end else begin
         for (int i = 0; i < dmamc_pkg::NCH; i++) begin
            if (grant_reg[i] && SVC_DONE[i]) begin
               grant_next[i] = 1'b0;
               if (CH_SNOOP[i]) begin
                  last_s_next = 2'(i);
               end else begin
                  last_p_next = 2'(i);
               end
            end
         end
         // each group searches on its own
         if ((grant_next & CH_SNOOP) == 4'h0) begin
            grant_next = grant_next | dmamc_pick(req & CH_SNOOP, last_s_next, rotating_priority_select_reg);
         end
         if ((grant_next & ~CH_SNOOP) == 4'h0) begin
            grant_next = grant_next | dmamc_pick(req & ~CH_SNOOP, last_p_next, rotating_priority_select_reg);
         end
      end
   end

   // arbiter registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         grant_reg <= 4'h0;
         last_s_reg <= 2'h0;
         last_p_reg <= 2'h0;
      end else begin
         grant_reg <= grant_next;
         last_s_reg <= last_s_next;
         last_p_reg <= last_p_next;
      end
   end

   assign GRANT = grant_reg;

   AST_EN_IGNORE: assert property (!en_reg |=> GRANT == 4'h0)
      else $error("grant issued while disabled");
   AST_FIXED_PRI: assert property (en_reg && !rotating_priority_select_reg && (grant_reg & ~CH_SNOOP) == 4'h0
                                   && req[0] && !CH_SNOOP[0] && $stable(CH_SNOOP)
                                   |=> GRANT[0])
      else $error("fixed priority did not favour channel 0");
   AST_ROTATE: assert property (en_reg && rotating_priority_select_reg && grant_reg[0] && SVC_DONE[0]
                                && (CH_SNOOP[1:0] == 2'b00) && req[1]
                                && (grant_reg & ~CH_SNOOP & 4'he) == 4'h0 |=> GRANT[1])
      else $error("rotating priority did not pass to next channel");
   AST_GROUPS: assert property (en_reg && grant_reg == 4'h0 && (req & CH_SNOOP) != 4'h0
                                && (req & ~CH_SNOOP) != 4'h0 |=> $countones(GRANT) == 2)
      else $error("groups did not arbitrate independently");

   // ---- shared buffer control
   logic [dmamc_pkg::PTR_W-1:0] wp_reg, wp_next;   // next location to fill
   logic [dmamc_pkg::PTR_W-1:0] rp_reg, rp_next;   // next location to drain
   logic [dmamc_pkg::CNT_W-1:0] cnt_reg, cnt_next; // words held
   logic wr_ok;                                    // accepted buffer write
   logic rd_ok;                                    // accepted buffer read
   dmamc_mem_if #(.WIDTH(dmamc_pkg::DATA_W), .AW(dmamc_pkg::PTR_W)) mem_port ();

   // only masked channels reach the buffer; sharing rules are software's
   assign FIFO_WR_READY = umask_reg[FIFO_WR_CH] && (cnt_reg != dmamc_pkg::BUF_FULL);
   assign FIFO_RD_READY = umask_reg[FIFO_RD_CH] && (cnt_reg != '0);
   assign wr_ok = FIFO_WR && FIFO_WR_READY;
   assign rd_ok = FIFO_RD && FIFO_RD_READY;
   assign buf_clear = !en_reg || (ctrl_wr && BUS_WDATA[dmamc_pkg::CLR_BIT]);

   // pointers move only on accepted strobes or a clear, so a halted channel's data stays
   always_comb begin
      wp_next = wp_reg;
      rp_next = rp_reg;
      cnt_next = cnt_reg;
      if (buf_clear) begin
         wp_next = '0;
         rp_next = '0;
         cnt_next = '0;
      end else begin
         if (wr_ok) begin
            wp_next = wp_reg + 3'h1;                 // natural wrap at eight
         end
         if (rd_ok) begin
            rp_next = rp_reg + 3'h1;
         end
         if (wr_ok && !rd_ok) begin
            cnt_next = cnt_reg + 4'h1;
         end else if (rd_ok && !wr_ok) begin
            cnt_next = cnt_reg - 4'h1;
         end
      end
   end

   // buffer pointer registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   assign mem_port.we = wr_ok;
   assign mem_port.waddr = wp_reg;
   assign mem_port.wdata = FIFO_WDATA;
   assign mem_port.re = rd_ok;
   assign mem_port.raddr = rp_reg;
   assign FIFO_RDATA = mem_port.rdata;   // word stands the cycle after the read

   // buffer storage
   dmamc_mem #(.WIDTH(dmamc_pkg::DATA_W), .DEPTH(dmamc_pkg::BUF_DEPTH)) u_mem (
      .clk(CLK),
      .reset_n(RESET_N),
      .port(mem_port.mem)
   );

   AST_CLEAR: assert property (ctrl_wr && BUS_WDATA[7] |=> cnt_reg == 4'h0 && wp_reg == 3'h0
                               && rp_reg == 3'h0)
      else $error("buffer clear left state behind");
   AST_HOLD: assert property (!wr_ok && !rd_ok && !buf_clear
                              |=> $stable(cnt_reg) && $stable(wp_reg) && $stable(rp_reg))
      else $error("buffer state moved without a strobe");
   AST_MASKED: assert property (FIFO_WR && !umask_reg[FIFO_WR_CH] && !buf_clear
                                |=> wp_reg == $past(wp_reg) && cnt_reg <= $past(cnt_reg))
      else $error("unmasked channel wrote the buffer");
   AST_STEP: assert property (wr_ok && !rd_ok && !buf_clear
                              |=> cnt_reg == $past(cnt_reg) + 4'h1 && wp_reg == $past(wp_reg) + 3'h1)
      else $error("count or pointer did not step by one");
   // a control write in the disabled cycle may lift the engine reset at the next edge
   AST_DISABLE: assert property (!en_reg |=> cnt_reg == 4'h0 && GRANT == 4'h0
                                 && (!ENGINE_RESET_N || $past(ctrl_wr)))
      else $error("disabled controller not held in reset");

   // ---- sticky events and interrupt
   logic [7:0] stat_reg, stat_next;     // sticky done and error edges
   logic [7:0] imask_reg, imask_next;   // interrupt mask
   logic [3:0] done_prev_reg;           // previous done conditions
   logic [3:0] err_prev_reg;            // previous error conditions
   logic [7:0] evt;                     // new rising conditions

   assign evt = {err_now & ~err_prev_reg, done_now & ~done_prev_reg};

   // a read clears, but an event in the same cycle still lands
   always_comb begin
      stat_next = (stat_reg & ~{8{stat_rd}}) | evt;
      imask_next = mask_wr ? BUS_WDATA[dmamc_pkg::IRQ_W-1:0] : imask_reg;
   end

   // event registers
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         stat_reg <= 8'h00;
         imask_reg <= dmamc_pkg::IRQ_MASK_RST;
         done_prev_reg <= 4'h0;
         err_prev_reg <= 4'h0;
      end else begin
         stat_reg <= stat_next;
         imask_reg <= imask_next;
         done_prev_reg <= done_now;
         err_prev_reg <= err_now;
      end
   end

   assign IRQ = |(stat_reg & imask_reg);

   // ---- read back, answered one cycle after the strobe
   logic [31:0] rdata_reg, rdata_next;   // registered read word

   // address decode; unmapped offsets read zero, reserved bits zero
   always_comb begin
      rdata_next = 32'h0;
      if (BUS_RD) begin
         if (BUS_ADDR == dmamc_pkg::OFF_CTRL) begin
            rdata_next[dmamc_pkg::ERR_LSB +: 4] = err_now;
            rdata_next[dmamc_pkg::DONE_LSB +: 4] = done_now;
            rdata_next[dmamc_pkg::CNT_LSB +: dmamc_pkg::CNT_W] = cnt_reg;
            rdata_next[dmamc_pkg::WP_LSB +: dmamc_pkg::PTR_W] = wp_reg;
            rdata_next[dmamc_pkg::RP_LSB +: dmamc_pkg::PTR_W] = rp_reg;
            rdata_next[dmamc_pkg::UMASK_LSB +: 4] = umask_reg;
            rdata_next[dmamc_pkg::LE_BIT] = le_reg;
            rdata_next[dmamc_pkg::ROTATING_PRIORITY_SELECT_BIT] = rotating_priority_select_reg;
            rdata_next[dmamc_pkg::EN_BIT] = en_reg;
         end else if (BUS_ADDR == dmamc_pkg::OFF_IRQ_STAT) begin
            rdata_next[dmamc_pkg::IRQ_W-1:0] = stat_reg;
         end else if (BUS_ADDR == dmamc_pkg::OFF_IRQ_MASK) begin
            rdata_next[dmamc_pkg::IRQ_W-1:0] = imask_reg;
         end
      end
   end

   // read data register
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rdata_reg <= 32'h0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign BUS_RDATA = rdata_reg;

   AST_DONE_BITS: assert property (BUS_RD && BUS_ADDR == 8'ha4
                                   |=> BUS_RDATA[25:24] == $past(done_now[1:0]))
      else $error("done status bits wrong");
   AST_ERR_BITS: assert property (BUS_RD && BUS_ADDR == 8'ha4
                                  |=> BUS_RDATA[31:28] == $past(CH_IRQ_ERR_EN & CH_CHAIN_ABNORMAL))
      else $error("error status bits wrong");
   AST_COUNT_RD: assert property (BUS_RD && BUS_ADDR == 8'ha4 |=> BUS_RDATA[17:14] == $past(cnt_reg))
      else $error("valid count field wrong");
   AST_WP_RD: assert property (BUS_RD && BUS_ADDR == 8'ha4 |=> BUS_RDATA[13:11] == $past(wp_reg))
      else $error("write pointer field wrong");
   AST_RP_RD: assert property (BUS_RD && BUS_ADDR == 8'ha4 |=> BUS_RDATA[10:8] == $past(rp_reg))
      else $error("read pointer field wrong");
endmodule : dmamc_top

// ---- dv/dmamc_peer.sv ----
// peripheral and transfer engine model: raises requests, ends granted service
// assumes grants are registered on the same clock as this model
`timescale 1ns/10ps
module dmamc_peer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] want,
   input wire logic slow,
   input wire logic [3:0] grant,
   output logic [3:0] dma_req,
   output logic [3:0] svc_done
);
   logic tick; // slow mode answers only on every other cycle
   // requests follow the wish; one done pulse per granted service
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_req <= 4'h0;
         svc_done <= 4'h0;
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
         dma_req <= want;
         // no second pulse while the grant drops after the first
         svc_done <= grant & ~svc_done & {4{tick | ~slow}};
      end
   end
endmodule : dmamc_peer

// ---- dv/dmamc_top_tb_top.sv ----
// self-checking bench for the dma global control block
// assumes the peer model stands in for peripherals and the engine
`timescale 1ns/10ps
module dmamc_top_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fw = 1'b0, fr = 1'b0, slow = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, frd, v, fdat;
   logic [3:0] ce = 4'h0, te = 4'h0, cn = 4'h0, tn = 4'h0, ee = 4'h0, ca = 4'h0;
   logic [3:0] snp = 4'h0, want = 4'h0, req, svc, gnt, g;
   logic [1:0] ch = 2'h0;
   logic eng_n, le, wrdy, rrdy, irq;
   int fails = 0, check_count = 0, cyc = 0;
   logic [31:0] q[$]; // words expected out of the buffer
   always #20 clk = ~clk;
   // hang guard, far above the few hundred cycles used
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         finish_test();
      end
   end
   dmamc_top DUT (.CLK(clk), .RESET_N(rst_n), .BUS_ADDR(addr), .BUS_WDATA(wdat), .BUS_WR(wr),
      .BUS_RD(rd), .BUS_RDATA(rdat), .CH_IRQ_CHAIN_EN(ce), .CH_IRQ_XFER_EN(te),
      .CH_CHAIN_NORMAL(cn), .CH_XFER_NORMAL(tn), .CH_IRQ_ERR_EN(ee), .CH_CHAIN_ABNORMAL(ca),
      .CH_SNOOP(snp), .DMA_REQ(req), .SVC_DONE(svc), .GRANT(gnt), .ENGINE_RESET_N(eng_n),
      .BYTE_ORDER_LE(le), .FIFO_WR(fw), .FIFO_WR_CH(ch), .FIFO_WDATA(wdat),
      .FIFO_WR_READY(wrdy), .FIFO_RD(fr), .FIFO_RD_CH(ch), .FIFO_RD_READY(rrdy),
      .FIFO_RDATA(fdat), .IRQ(irq));
   dmamc_peer peer (.clk(clk), .reset_n(rst_n), .want(want), .slow(slow), .grant(gnt),
      .dma_req(req), .svc_done(svc));
   // one compare, counted, reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one register cycle; read data lands in v
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      v = rdat;
   endtask : bus
   // one buffer strobe; accepted pushes are queued for later compare
   task automatic fop(input logic w, input logic [1:0] c);
      @(posedge clk);
      ch <= c;
      wdat <= $urandom;
      fw <= w;
      fr <= ~w;
      #1;
      if (w && wrdy) q.push_back(wdat);
      @(posedge clk);
      fw <= 1'b0;
      fr <= 1'b0;
      #1;
      frd = fdat;
   endtask : fop
   // wait for a grant other than the last one, bounded
   task automatic wait_g(input logic [3:0] last);
      int n = 0;
      while ((gnt === 4'h0 || gnt === last) && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
      g = gnt;
   endtask : wait_g
   function automatic logic [31:0] stat_exp();
      stat_exp = {ee & ca, (ce & cn) | (te & tn), 24'h0};
   endfunction : stat_exp
   function automatic logic [31:0] fld(input logic [3:0] c, input logic [2:0] w, r);
      fld = {14'h0, c, w, r, 8'h0};
   endfunction : fld
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   initial begin
      void'($urandom(16));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'ha4, 32'h0);
      chk(v, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(v, 32'h0);
      // live status against random enables and flags
      repeat (12) begin
         {ce, te, cn, tn} <= $urandom;
         {ee, ca} <= $urandom;
         bus(1'b0, 8'ha4, 32'h0);
         chk(v & 32'hff000000, stat_exp());
      end
      {ce, te, cn, tn, ee, ca} <= 24'h0;
      bus(1'b1, 8'hac, 32'h01);
      bus(1'b0, 8'ha8, 32'h0);
      {te, tn} <= 8'h33;
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b1);
      bus(1'b0, 8'ha8, 32'h0);
      chk(v, 32'h03);
      chk(irq, 1'b0);
      {ee, ca} <= 8'h22;
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b0);
      bus(1'b0, 8'ha8, 32'h0);
      chk(v, 32'h20);
      // byte order both ways, enabled, all channels may use the buffer
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, 8'ha4, 32'h79 | (i << 2));
         chk(le, i[0]);
         chk(eng_n, 1'b1);
      end
      repeat (9) fop(1'b1, 2'($urandom));
      chk(wrdy, 1'b0);
      chk(rrdy, 1'b1);
      bus(1'b0, 8'ha4, 32'h0);
      chk(v & 32'h3ff00, fld(4'h8, 3'h0, 3'h0));
      repeat (3) begin
         fop(1'b0, 2'($urandom));
         chk(frd, q.pop_front());
      end
      bus(1'b1, 8'ha4, 32'h09);
      fop(1'b1, 2'h1);
      fop(1'b0, 2'h2);
      bus(1'b0, 8'ha4, 32'h0);
      chk(v & 32'h3ff00, fld(4'h5, 3'h0, 3'h3));
      fop(1'b0, 2'h0);
      chk(frd, q.pop_front());
      bus(1'b1, 8'ha4, 32'h89);
      bus(1'b0, 8'ha4, 32'h0);
      chk(v & 32'h3ff80, 32'h0);
      chk(rrdy, 1'b0);
      q.delete();
      fop(1'b1, 2'h0);
      bus(1'b1, 8'ha4, 32'h08);
      chk(eng_n, 1'b0);
      bus(1'b0, 8'ha4, 32'h0);
      chk(v & 32'h3ff00, 32'h0);
      // arbiter: disabled, fixed, two groups, rotating
      want <= 4'hf;
      repeat (12) @(posedge clk);
      #1;
      chk(gnt, 4'h0);
      // let the filtered requests settle before enabling
      want <= 4'he;
      repeat (6) @(posedge clk);
      bus(1'b1, 8'ha4, 32'h01);
      wait_g(4'h0);
      chk(g, 4'h2);
      bus(1'b1, 8'ha4, 32'h00);
      want <= 4'hf;
      repeat (6) @(posedge clk);
      bus(1'b1, 8'ha4, 32'h01);
      wait_g(4'h0);
      chk(g, 4'h1);
      bus(1'b1, 8'ha4, 32'h00);
      snp <= 4'h3;
      bus(1'b1, 8'ha4, 32'h01);
      wait_g(4'h0);
      chk(g, 4'h5);
      bus(1'b1, 8'ha4, 32'h00);
      snp <= 4'h0;
      slow <= 1'b1;
      bus(1'b1, 8'ha4, 32'h03);
      wait_g(4'h0);
      repeat (5) begin
         v = {28'h0, g};
         wait_g(g);
         chk(g, {v[2:0], v[3]});
      end
      finish_test();
   end
endmodule : dmamc_top_tb_top
